// [core/adc_cmd_pkg.sv]
// Purpose: Shared constants, types and decoding for the ADC command interpreter.
// Assumes: Fixed 24-bit link words; 16-bit items sit MSB aligned in them.
// Notes: Register map contents live outside the interpreter.
`default_nettype none
package adc_cmd_pkg;
  localparam int WORD_BITS = 24;
  localparam int CMD_BITS = 16;
  localparam int PAD_BITS = WORD_BITS - CMD_BITS;
  localparam int ADDR_BITS = 6;
  localparam int CNT_BITS = 7;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 7;
  localparam int CNT_MSB = 6;
  localparam int FRAME_WORDS = 4;
  localparam int CHANNELS = 2;
  localparam int SAMPLE_FIFO_DEPTH = 16;
  localparam logic [15:0] CMD_NOP = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [15:0] CMD_STANDBY = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP = 16'h0033;
  localparam logic [15:0] CMD_LOCK = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK = 16'h0655;
  localparam logic [15:0] RESP_RESET_OK = 16'hFF42;
  localparam logic [15:0] RESP_RESET_SHORT = 16'h0011;
  localparam logic [2:0] OP_READ = 3'h5;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] RESP_READ_MULTI = 3'h7;
  localparam logic [2:0] RESP_WRITE = 3'h2;
  localparam logic [23:0] CODE_MAX = 24'h7FFFFF;
  localparam logic [23:0] CODE_MIN = 24'h800000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_EXEC = 2'b10,
    ST_LOAD = 2'b11
  } frame_state_t;

  typedef enum logic [2:0] {
    K_NOP = 3'b000,
    K_RESET = 3'b001,
    K_STANDBY = 3'b010,
    K_WAKEUP = 3'b011,
    K_LOCK = 3'b100,
    K_UNLOCK = 3'b101,
    K_READ_REGISTERS_CMD = 3'b110,
    K_WRITE_REGISTERS_CMD = 3'b111
  } cmd_kind_t;

  // Unknown words fall through to the no-operation kind.
  function automatic cmd_kind_t decode_cmd(input logic [15:0] w);
    cmd_kind_t k;
    k = K_NOP;
    case (w)
      CMD_RESET: k = K_RESET;
      CMD_STANDBY: k = K_STANDBY;
      CMD_WAKEUP: k = K_WAKEUP;
      CMD_LOCK: k = K_LOCK;
      CMD_UNLOCK: k = K_UNLOCK;
      default: begin
        if (w[15:13] == OP_READ) k = K_READ_REGISTERS_CMD;
        else if (w[15:13] == OP_WRITE) k = K_WRITE_REGISTERS_CMD;
      end
    endcase
    return k;
  endfunction
endpackage
`default_nettype wire

// [core/adc_spi_command_decoder.sv]
// Purpose: SPI command interpreter and output code formatter of a two-channel ADC.
// Assumes: SPI mode 1, 24-bit words, link pins sampled by the reference clock.
// Notes: Register storage and check-word generation sit outside this block.
// Operation
// - Clip results: at or below negative full scale 800000h, top end 7FFFFFh.
// - Zero gives 000000h, one LSB gives 000001h, minus one LSB all ones.
// - Response to a command goes out as first word of the next frame.
// - Unknown words behave as the no-operation word.
// - Reset word latched at frame end, then all registers go to defaults.
// - Completed reset answers FF42h; incomplete reset frame answers 0011h, no reset.
// - Standby word latched at frame end enters standby and is echoed.
// - Standby while already in standby changes nothing.
// - Wakeup word leaves standby and is echoed; no effect when converting.
// - Lock word locks and is echoed; locked accepts only no-op, read, unlock.
// - Conversion data keeps flowing out while locked.
// - Unlock word 0655h leaves the locked state and is echoed.
// - Single register read answers the register contents next frame.
// - Multi read answers 111 header then count-plus-one consecutive registers.
// - Write answers 010 header with written count minus one.
// - Failed check word skips the command unless it is a write.
// - Reset happens only when the whole frame was received.
// - Frame after a multi read carries register words instead of conversion data.
// - Writes skip read-only, gap and out-of-range addresses and do not count them.
`timescale 1ns/1ps
`default_nettype none
module adc_spi_command_decoder
  import adc_cmd_pkg::*;
#(
  parameter int RAW_W = 26,
  parameter int FIFO_DEPTH = SAMPLE_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  input wire logic i_sample_valid,
  input wire logic signed [RAW_W-1:0] i_sample_raw,
  output logic o_sample_ready,
  output logic o_conv_ready_n,
  output logic [ADDR_BITS-1:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [CMD_BITS-1:0] o_reg_wdata,
  input wire logic [CMD_BITS-1:0] i_reg_rdata,
  input wire logic i_reg_writable,
  input wire logic [CMD_BITS-1:0] i_status,
  input wire logic i_check_en,
  input wire logic [CMD_BITS-1:0] i_check_word,
  output logic o_soft_reset,
  output logic o_standby,
  output logic o_locked
);
  localparam int LW = $clog2(FIFO_DEPTH+1);
  logic [2:0] pins;
  logic cs_n_prev_reg, sclk_prev_reg;
  logic cs_start, cs_end, sclk_rise, sclk_fall;
  frame_state_t state_reg;
  logic [WORD_BITS-1:0] sh_in_reg, sh_out_reg, out_word_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] word_cnt_reg;
  logic word_done_reg;
  logic [CMD_BITS-1:0] cmd_reg, rx_check_reg, resp_reg, rx_word;
  logic got_check_reg;
  logic [CNT_BITS:0] cmd_cnt;
  logic [ADDR_BITS+1:0] wr_addr;
  logic wr_pend_reg, wr_oor_reg;
  logic [7:0] wr_count_reg;
  logic multi_reg, fetch_pend_reg, fetch_now_reg;
  logic [ADDR_BITS:0] rd_ptr_reg;
  logic [7:0] rd_left_reg;
  cmd_kind_t cmd_kind, eff_kind;
  logic full_frame, check_bad;
  logic signed [RAW_W-1:0] raw_max, raw_min;
  logic [WORD_BITS-1:0] sat_code;
  logic fifo_valid, fifo_pop;
  logic [WORD_BITS-1:0] fifo_data;
  logic [LW-1:0] fifo_level;

  pin_sync3 #(.WIDTH(3), .RESET_VAL(3'h1)) pin_sync3_i (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pin({i_din, i_sclk, i_cs_n}),
    .o_level(pins)
  );

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_n_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b0;
    end else begin
      cs_n_prev_reg <= pins[0];
      sclk_prev_reg <= pins[1];
    end
  end

  assign cs_start = cs_n_prev_reg && !pins[0];
  assign cs_end = !cs_n_prev_reg && pins[0];
  assign sclk_rise = !sclk_prev_reg && pins[1] && !pins[0];
  assign sclk_fall = sclk_prev_reg && !pins[1] && !pins[0];

  // Output code formatting: clip the raw result to the 24-bit range.
  assign raw_max = RAW_W'($signed(CODE_MAX));
  assign raw_min = -(RAW_W'($signed(CODE_MAX))) - RAW_W'(1);
  always_comb begin
    if (i_sample_raw >= raw_max) sat_code = CODE_MAX;
    else if (i_sample_raw <= raw_min) sat_code = CODE_MIN;
    else sat_code = i_sample_raw[WORD_BITS-1:0];
  end

  sample_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) sample_fifo_i (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_flush(o_soft_reset),
    .i_in_valid(i_sample_valid),
    .i_in_data(sat_code),
    .o_in_ready(o_sample_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(fifo_pop),
    .o_level(fifo_level)
  );

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) o_conv_ready_n <= 1'b1;
    else o_conv_ready_n <= (fifo_level < LW'(CHANNELS));
  end

  // Bit engine: shift out on rising SCLK, sample on falling SCLK.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_in_reg <= '0;
      sh_out_reg <= '0;
      bit_cnt_reg <= '0;
      word_cnt_reg <= '0;
      word_done_reg <= 1'b0;
      o_dout <= 1'b0;
    end else begin
      word_done_reg <= 1'b0;
      if (cs_start) begin
        bit_cnt_reg <= '0;
        word_cnt_reg <= '0;
      end else if (cs_end) begin
        o_dout <= 1'b0;
      end else if (sclk_rise) begin
        if (bit_cnt_reg == '0) begin
          sh_out_reg <= out_word_reg;
          o_dout <= out_word_reg[WORD_BITS-1];
        end else begin
          sh_out_reg <= {sh_out_reg[WORD_BITS-2:0], 1'b0};
          o_dout <= sh_out_reg[WORD_BITS-2];
        end
      end else if (sclk_fall) begin
        sh_in_reg <= {sh_in_reg[WORD_BITS-2:0], pins[2]};
        if (bit_cnt_reg == 5'(WORD_BITS-1)) begin
          bit_cnt_reg <= '0;
          word_done_reg <= 1'b1;
          if (word_cnt_reg != 8'hFF) word_cnt_reg <= word_cnt_reg + 8'h01;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
    end
  end

  assign rx_word = sh_in_reg[WORD_BITS-1:PAD_BITS];
  assign cmd_kind = decode_cmd(cmd_reg);
  assign cmd_cnt = {1'b0, cmd_reg[CNT_MSB:0]};
  assign wr_addr = {2'b00, cmd_reg[ADDR_MSB:ADDR_LSB]} + 8'(word_cnt_reg - 8'h02);

  // Command and check word capture.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_reg <= CMD_NOP;
      rx_check_reg <= '0;
      got_check_reg <= 1'b0;
    end else if (cs_start) begin
      cmd_reg <= CMD_NOP;
      got_check_reg <= 1'b0;
    end else if (word_done_reg) begin
      if (word_cnt_reg == 8'h01) cmd_reg <= rx_word;
      else if (word_cnt_reg == ((cmd_kind == K_WRITE_REGISTERS_CMD) ? 8'(cmd_cnt) + 8'h03 : 8'h02)) begin
        rx_check_reg <= rx_word;
        got_check_reg <= 1'b1;
      end
    end
  end

  // Writes go out as each data word arrives, even before the check word.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_reg <= 1'b0;
      wr_oor_reg <= 1'b0;
      wr_count_reg <= '0;
      o_reg_wr <= 1'b0;
      o_reg_wdata <= '0;
    end else begin
      o_reg_wr <= 1'b0;
      wr_pend_reg <= 1'b0;
      if (cs_start) wr_count_reg <= '0;
      if (word_done_reg && cmd_kind == K_WRITE_REGISTERS_CMD && !o_locked && word_cnt_reg >= 8'h02 &&
          word_cnt_reg <= 8'(cmd_cnt) + 8'h02) begin
        wr_pend_reg <= 1'b1;
        wr_oor_reg <= |wr_addr[ADDR_BITS+1:ADDR_BITS];
        o_reg_wdata <= rx_word;
      end
      if (wr_pend_reg && i_reg_writable && !wr_oor_reg) begin
        o_reg_wr <= 1'b1;
        wr_count_reg <= wr_count_reg + 8'h01;
      end
    end
  end

  // Register address: write target, then read prefetch one cycle later.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) o_reg_addr <= '0;
    else if (word_done_reg) o_reg_addr <= wr_addr[ADDR_BITS-1:0];
    else if (fetch_pend_reg) o_reg_addr <= rd_ptr_reg[ADDR_BITS-1:0];
    else if (state_reg == ST_EXEC) o_reg_addr <= cmd_reg[ADDR_MSB:ADDR_LSB];
  end

  assign fifo_pop = word_done_reg && !multi_reg && word_cnt_reg <= 8'(CHANNELS) && fifo_valid;

  // Outgoing word preparation.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      out_word_reg <= '0;
      fetch_pend_reg <= 1'b0;
      fetch_now_reg <= 1'b0;
      rd_left_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      fetch_pend_reg <= 1'b0;
      fetch_now_reg <= fetch_pend_reg;
      if (cs_start) out_word_reg <= {resp_reg, PAD_BITS'(0)};
      else if (word_done_reg) begin
        if (multi_reg && rd_left_reg != '0) begin
          fetch_pend_reg <= 1'b1;
          out_word_reg <= '0;
        end else if (fifo_pop) out_word_reg <= fifo_data;
        else out_word_reg <= '0;
      end else if (fetch_now_reg) begin
        out_word_reg <= {i_reg_rdata, PAD_BITS'(0)};
        rd_left_reg <= rd_left_reg - 8'h01;
        rd_ptr_reg <= rd_ptr_reg + 7'h01;
      end
      if (state_reg == ST_EXEC && eff_kind == K_READ_REGISTERS_CMD) begin
        rd_ptr_reg <= {1'b0, cmd_reg[ADDR_MSB:ADDR_LSB]};
        rd_left_reg <= 8'(cmd_cnt) + 8'h01;
      end
    end
  end

  assign full_frame = (word_cnt_reg >= 8'(FRAME_WORDS));
  assign check_bad = i_check_en && (!got_check_reg || rx_check_reg != i_check_word);

  always_comb begin
    eff_kind = cmd_kind;
    if (word_cnt_reg == '0) eff_kind = K_NOP;
    if (check_bad && eff_kind != K_WRITE_REGISTERS_CMD) eff_kind = K_NOP;
    if (o_locked && eff_kind != K_READ_REGISTERS_CMD && eff_kind != K_UNLOCK) eff_kind = K_NOP;
  end

  // Frame sequencing.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) state_reg <= ST_IDLE;
    else begin
      case (state_reg)
        ST_IDLE: if (cs_start) state_reg <= ST_SHIFT;
        ST_SHIFT: if (cs_end) state_reg <= ST_EXEC;
        ST_EXEC: state_reg <= (eff_kind == K_READ_REGISTERS_CMD && cmd_cnt == '0) ? ST_LOAD : ST_IDLE;
        ST_LOAD: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Command execution at frame end.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      resp_reg <= CMD_NOP;
      o_soft_reset <= 1'b0;
      o_standby <= 1'b0;
      o_locked <= 1'b0;
      multi_reg <= 1'b0;
    end else begin
      o_soft_reset <= 1'b0;
      if (state_reg == ST_LOAD) resp_reg <= i_reg_rdata;
      if (state_reg == ST_EXEC) begin
        multi_reg <= 1'b0;
        case (eff_kind)
          K_RESET: begin
            if (full_frame) begin
              o_soft_reset <= 1'b1;
              o_standby <= 1'b0;
              o_locked <= 1'b0;
              resp_reg <= RESP_RESET_OK;
            end else begin
              resp_reg <= RESP_RESET_SHORT;
            end
          end
          K_STANDBY: begin
            o_standby <= 1'b1;
            resp_reg <= cmd_reg;
          end
          K_WAKEUP: begin
            o_standby <= 1'b0;
            resp_reg <= cmd_reg;
          end
          K_LOCK: begin
            o_locked <= 1'b1;
            resp_reg <= cmd_reg;
          end
          K_UNLOCK: begin
            o_locked <= 1'b0;
            resp_reg <= cmd_reg;
          end
          K_READ_REGISTERS_CMD: begin
            if (cmd_cnt != '0) begin
              multi_reg <= 1'b1;
              resp_reg <= {RESP_READ_MULTI, cmd_reg[ADDR_MSB:0]};
            end
          end
          K_WRITE_REGISTERS_CMD: resp_reg <= {RESP_WRITE, cmd_reg[ADDR_MSB:ADDR_LSB], 7'(wr_count_reg - 8'h01)};
          default: resp_reg <= i_status;
        endcase
      end
    end
  end

  property p_sat_hi;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_sample_raw >= raw_max) |-> (sat_code == 24'h7FFFFF);
  endproperty
  a_sat_hi: assert property (p_sat_hi) else $error("positive clip code wrong");

  property p_sat_lo;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_sample_raw <= raw_min) |-> (sat_code == 24'h800000);
  endproperty
  a_sat_lo: assert property (p_sat_lo) else $error("negative clip code wrong");

  property p_small_codes;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_sample_raw == -RAW_W'(1)) |-> (sat_code == 24'hFFFFFF);
  endproperty
  a_small_codes: assert property (p_small_codes) else $error("minus one LSB code wrong");

  property p_resp_first;
    @(posedge i_ref_clk) disable iff (i_rst)
      (cs_start && state_reg == ST_IDLE) |=> (out_word_reg[WORD_BITS-1:PAD_BITS] == $past(resp_reg));
  endproperty
  a_resp_first: assert property (p_resp_first) else $error("first word is not the response");

  property p_reset_full;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == ST_EXEC && eff_kind == K_RESET && full_frame)
        |=> (o_soft_reset && resp_reg == 16'hFF42) ##1 !o_soft_reset;
  endproperty
  a_reset_full: assert property (p_reset_full) else $error("reset did not fire once");

  property p_reset_short;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == ST_EXEC && eff_kind == K_RESET && !full_frame)
        |=> (!o_soft_reset && resp_reg == 16'h0011);
  endproperty
  a_reset_short: assert property (p_reset_short) else $error("short reset frame misbehaved");

  property p_nop_status;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == ST_EXEC && eff_kind == K_NOP)
        |=> (resp_reg == $past(i_status) && o_standby == $past(o_standby) && o_locked == $past(o_locked));
  endproperty
  a_nop_status: assert property (p_nop_status) else $error("no-op changed state");

  property p_lock_guard;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == ST_EXEC && o_locked && cmd_kind == K_STANDBY && !o_standby)
        |=> !o_standby;
  endproperty
  a_lock_guard: assert property (p_lock_guard) else $error("locked device accepted standby");

  property p_standby_echo;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == ST_EXEC && eff_kind == K_STANDBY) |=> (o_standby && resp_reg == 16'h0022);
  endproperty
  a_standby_echo: assert property (p_standby_echo) else $error("standby not entered");

  property p_no_write_locked;
    @(posedge i_ref_clk) disable iff (i_rst)
      (o_locked && $stable(o_locked)) |-> !o_reg_wr;
  endproperty
  a_no_write_locked: assert property (p_no_write_locked) else $error("write while locked");
endmodule // adc_spi_command_decoder
`default_nettype wire

// [core/pin_sync3.sv]
// Purpose: Three-stage synchroniser for asynchronous pins with agreement filter.
// Assumes: Pins change slowly compared with the reference clock.
// Notes: The level moves only when the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) o_level[g] <= RESET_VAL[g];
      else if (s2_reg[g] == s3_reg[g]) o_level[g] <= s3_reg[g];
    end
  end
endmodule // pin_sync3
`default_nettype wire

// [core/sample_fifo.sv]
// Purpose: Conversion sample FIFO between the converter path and the link.
// Assumes: Single clock; flush empties it in one cycle.
// Notes: Input ready is registered so the top can drive it straight out.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CW-1:0] count_next;
  logic push, pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;
  assign o_out_valid = (o_level != '0);
  assign o_out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = o_level;
    if (push && !pop) count_next = o_level + CW'(1);
    else if (pop && !push) count_next = o_level - CW'(1);
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) mem[wr_ptr_reg] <= i_in_data;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      o_level <= '0;
      o_in_ready <= 1'b0;
    end else if (i_flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      o_level <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + PW'(1);
      if (pop) rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + PW'(1);
      o_level <= count_next;
      o_in_ready <= (count_next != CW'(DEPTH));
    end
  end
endmodule // sample_fifo
`default_nettype wire

// [tb/spi_host_model.sv]
// Purpose: Behavioural SPI controller that plays the host side of the command link.
// Assumes: Mode 1 timing, 80 ns link clock, 24-bit words, MSB first.
// Notes: The data line shows the inverse of its last bit while deselected.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input wire logic i_dout,
  output logic o_done
);
  logic [23:0] tx[8];
  logic [23:0] rx[8];
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b1;
    o_done = 1'b0;
    tx = '{default: 24'h0};
  end
  // Answers are collected in the frame after the one that carried the command.
  task automatic xfer(input int nbits);
    o_cs_n = 1'b0;
    #100;
    for (int k = 0; k < nbits; k++) begin
      o_din = tx[k / 24][23 - k % 24];
      o_sclk = 1'b1;
      #40;
      o_sclk = 1'b0;
      rx[k / 24][23 - k % 24] = i_dout;
      #40;
    end
    o_din = ~o_din;
    #60;
    o_cs_n = 1'b1;
    #200;
    o_done = 1'b1;
    #1;
    o_done = 1'b0;
  endtask
endmodule // spi_host_model
`default_nettype wire

// [tb/test_adc_spi_command_decoder.sv]
// Purpose: Self-checking bench for the ADC command interpreter.
// Assumes: The host model drives the link; the bench plays register map and sample source.
// Notes: Expected words wait in a queue until the host finishes the frame.
`timescale 1ns/1ps
`default_nettype none
module test_adc_spi_command_decoder;
  import adc_cmd_pkg::*;
  localparam int SETTLE_NS = 2000;
  logic clk, rst, sclk, cs_n, din, dout, done, s_valid, s_ready, cr_n, wr, wrt, sr, sb, lk;
  logic signed [25:0] raw;
  logic [5:0] addr;
  logic [15:0] wdata, st, wd, r0, ck;
  logic ck_en;
  logic [15:0] regs[64];
  logic [15:0] rsp[9];
  logic [15:0] cmds[9];
  logic [8:0] sbv, lkv;
  logic [23:0] eq[$];
  logic [23:0] sq[$];
  int nq[$];
  int seed = 32'h3B1DD9F9;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int nsr = 0;
  assign wrt = (addr != 6'h00);
  adc_spi_command_decoder adc_spi_command_decoder_i (
    .i_ref_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .o_dout(dout),
    .i_sample_valid(s_valid), .i_sample_raw(raw), .o_sample_ready(s_ready), .o_conv_ready_n(cr_n),
    .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wdata), .i_reg_rdata(regs[addr]),
    .i_reg_writable(wrt), .i_status(st), .i_check_en(ck_en), .i_check_word(ck),
    .o_soft_reset(sr), .o_standby(sb), .o_locked(lk));
  spi_host_model spi_host_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout), .o_done(done));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic push(input logic signed [25:0] v);
    @(negedge clk);
    s_valid = 1'b1;
    raw = v;
    do @(posedge clk); while (s_ready !== 1'b1);
    @(negedge clk);
    s_valid = 1'b0;
    sq.push_back(v > 26'sh07FFFFF ? CODE_MAX : v < -26'sh0800000 ? CODE_MIN : v[23:0]);
  endtask
  task automatic frm(input logic [15:0] cmd, input int nw, input int bits);
    spi_host_model_i.tx[0] = {cmd, 8'h00};
    nq.push_back(nw);
    spi_host_model_i.xfer(bits);
  endtask
  always @(posedge done) begin : watch
    int n;
    n = nq.pop_front();
    for (int k = 0; k < n; k++) chk(spi_host_model_i.rx[k], eq.pop_front());
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr === 1'b1 && wrt) regs[addr] <= wdata;
    if (sr === 1'b1) nsr <= nsr + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1;
    s_valid = 1'b0;
    raw = '0;
    ck_en = 1'b0;
    ck = 16'h0000;
    st = 16'($random(seed));
    for (int k = 0; k < 64; k++) regs[k] = 16'($random(seed));
    cmds = '{CMD_NOP, 16'h0666, CMD_STANDBY, CMD_STANDBY, CMD_WAKEUP, CMD_LOCK, CMD_STANDBY, CMD_UNLOCK, CMD_NOP};
    rsp = '{16'h0000, st, st, CMD_STANDBY, CMD_STANDBY, CMD_WAKEUP, CMD_LOCK, st, CMD_UNLOCK};
    sbv = 9'h00C;
    lkv = 9'h060;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    for (int k = 0; k < 16; k++) begin
      push(k == 0 ? 26'sh1000000 : k == 1 ? -26'sh1FFFFFF : k == 2 ? 26'sh0 : k == 3 ? 26'sh1 :
           k == 4 ? -26'sh1 : k == 5 ? 26'sh07FFFFF : k == 6 ? -26'sh0800000 : 26'($random(seed)));
    end
    repeat (3) @(negedge clk);
    chk(24'(s_ready), 24'h0);
    chk(24'(cr_n), 24'h0);
    for (int i = 0; i < 9; i++) begin
      eq.push_back({rsp[i], 8'h00});
      for (int k = 0; k < 2; k++) eq.push_back(sq.size() > 0 ? sq.pop_front() : 24'h0);
      frm(cmds[i], 3, 96);
      chk(24'(sb), 24'(sbv[i]));
      chk(24'(lk), 24'(lkv[i]));
    end
    wd = 16'($random(seed));
    r0 = regs[0];
    spi_host_model_i.tx[1] = {16'($random(seed)), 8'h00};
    spi_host_model_i.tx[2] = {wd, 8'h00};
    eq.push_back({st, 8'h00});
    frm(16'h6001, 1, 96);
    chk(24'(regs[1]), 24'(wd));
    chk(24'(regs[0]), 24'(r0));
    spi_host_model_i.tx[1] = 24'h0;
    spi_host_model_i.tx[2] = 24'h0;
    eq.push_back({16'h4000, 8'h00});
    frm(16'hA082, 1, 96);
    push(26'sh0000123);
    push(26'sh0000456);
    eq.push_back({16'hE082, 8'h00});
    for (int k = 1; k < 4; k++) eq.push_back({regs[k], 8'h00});
    frm(16'hA280, 4, 96);
    eq.push_back({regs[5], 8'h00});
    frm(CMD_RESET, 1, 24);
    chk(24'(nsr), 24'h0);
    eq.push_back({RESP_RESET_SHORT, 8'h00});
    frm(CMD_RESET, 1, 96);
    #SETTLE_NS;
    eq.push_back({RESP_RESET_OK, 8'h00});
    eq.push_back(24'h0);
    eq.push_back(24'h0);
    frm(CMD_NOP, 3, 96);
    chk(24'(nsr), 24'h1);
    @(negedge clk);
    ck_en = 1'b1;
    ck = 16'($random(seed)) | 16'h0001;
    eq.push_back({st, 8'h00});
    frm(CMD_LOCK, 1, 96);
    chk(24'(lk), 24'h0);
    spi_host_model_i.tx[1] = {ck, 8'h00};
    eq.push_back({st, 8'h00});
    frm(CMD_LOCK, 1, 96);
    chk(24'(lk), 24'h1);
    spi_host_model_i.tx[1] = {~wd, 8'h00};
    spi_host_model_i.tx[2] = {ck, 8'h00};
    eq.push_back({CMD_LOCK, 8'h00});
    frm(16'h6080, 1, 96);
    chk(24'(regs[1]), 24'(wd));
    eq.push_back({st, 8'h00});
    frm(CMD_NOP, 1, 96);
    wrap_up();
  end
endmodule // test_adc_spi_command_decoder
`default_nettype wire
